// >>> rtl/tws_master.sv
// Other end: two-wire master issuing writes and random or current reads.
`timescale 1ns/1ps
`default_nettype none
module tws_master import tws_pkg::*; #(
  parameter int HALF = TWS_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  tws_if.master bus,
  input wire logic cmd_go,
  input wire logic cmd_read,
  input wire logic cmd_rand,
  input wire logic [6:0] cmd_id,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_count,
  output logic busy,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic nack
);
  typedef enum {TM_IDLE, TM_START, TM_BIT, TM_ACK, TM_STOP} tm_st_t;
  tm_st_t st;
  logic [15:0] div;
  logic [1:0] ph;
  logic [7:0] sh;
  logic [3:0] bitn;
  logic [2:0] step;
  logic rx;
  logic [7:0] left;
  logic sda_a, sda_s;
  wire tick = (div == 16'(HALF - 1));

  // Sampled data line for reads and acknowledges.
  always_ff @(posedge core_clk) begin
    sda_a <= bus.sda;
    sda_s <= sda_a;
  end

  // Divider: one enable pulse per quarter of the clock period it makes.
  always_ff @(posedge core_clk) begin
    if (!rst_n || st == TM_IDLE) begin
      div <= 16'h0000;
    end else begin
      div <= tick ? 16'h0000 : div + 16'h0001;
    end
  end

  // Transfer sequencer; phases 0-1 clock low, 2-3 clock high.
  always_ff @(posedge core_clk) begin
    rd_valid <= 1'b0;
    if (!rst_n) begin
      st <= TM_IDLE;
      bus.scl_o <= 1'b0;
      bus.scl_oe <= 1'b0;
      bus.sda_m_o <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      ph <= 2'h0;
      sh <= 8'h00;
      bitn <= 4'h0;
      step <= 3'h0;
      rx <= 1'b0;
      left <= 8'h00;
      rd_byte <= 8'h00;
    end else if (st == TM_IDLE) begin
      if (cmd_go) begin // [R1]
        busy <= 1'b1;
        nack <= 1'b0;
        left <= cmd_count;
        step <= (cmd_read && !cmd_rand) ? 3'h3 : 3'h0;
        st <= TM_START;
        ph <= 2'h0;
      end
    end else if (tick) begin
      ph <= ph + 2'h1;
      unique case (st)
        TM_START: begin
          // START: data falls while clock high.
          if (ph == 2'h0) begin
            bus.scl_oe <= 1'b0;
            bus.sda_m_oe <= 1'b0;
          end else if (ph == 2'h2) begin
            bus.sda_m_oe <= 1'b1; // [R5]
          end else if (ph == 2'h3) begin
            bus.scl_oe <= 1'b1;
            st <= TM_BIT;
            bitn <= 4'h0;
            rx <= 1'b0;
            sh <= (step == 3'h3) ? {cmd_id, 1'b1} : {cmd_id, 1'b0}; // [R12] [R16]
          end
        end
        TM_BIT: begin
          if (ph == 2'h0) begin
            bus.sda_m_oe <= rx ? 1'b0 : ~sh[7]; // [R2] [R3]
          end else if (ph == 2'h1) begin
            bus.scl_oe <= 1'b0;
          end else if (ph == 2'h2 && rx) begin
            sh <= {sh[6:0], sda_s};
          end else if (ph == 2'h3) begin
            bus.scl_oe <= 1'b1;
            if (!rx) begin
              sh <= {sh[6:0], 1'b0};
            end
            bitn <= bitn + 4'h1;
            if (bitn == TWS_BITS - 4'h1) begin
              st <= TM_ACK;
            end
          end
        end
        TM_ACK: begin
          if (ph == 2'h0) begin
            bus.sda_m_oe <= rx && left != 8'h01; // [R8] [R10]
            if (rx) begin
              rd_byte <= sh;
              rd_valid <= 1'b1;
            end
          end else if (ph == 2'h1) begin
            bus.scl_oe <= 1'b0;
          end else if (ph == 2'h2 && !rx && sda_s) begin
            nack <= 1'b1;
          end else if (ph == 2'h3 && nack) begin
            // Refused byte: pull the clock low first so the STOP that follows is clean.
            bus.scl_oe <= 1'b1;
            st <= TM_STOP; // [R7]
          end else if (ph == 2'h3) begin
            bus.scl_oe <= 1'b1;
            bitn <= 4'h0;
            st <= TM_BIT;
            unique case (step)
              3'h0: begin
                sh <= cmd_addr;
                step <= 3'h1;
              end
              3'h1: begin
                if (cmd_read) begin
                  step <= 3'h3; // [R18]
                  st <= TM_START;
                end else begin
                  sh <= cmd_wdata;
                  step <= 3'h2;
                end
              end
              3'h2: st <= TM_STOP; // [R17]
              3'h3: begin
                rx <= 1'b1;
                step <= 3'h4;
              end
              default: begin
                left <= left - 8'h01;
                if (left == 8'h01) begin
                  st <= TM_STOP; // [R19]
                end
              end
            endcase
          end
        end
        TM_STOP: begin
          // STOP: data rises while clock high.
          if (ph == 2'h0) begin
            bus.sda_m_oe <= 1'b1;
          end else if (ph == 2'h1) begin
            bus.scl_oe <= 1'b0;
          end else if (ph == 2'h3) begin
            bus.sda_m_oe <= 1'b0; // [R7]
            st <= TM_IDLE;
            busy <= 1'b0;
          end
        end
        default: st <= TM_IDLE;
      endcase
    end
  end
endmodule : tws_master
`default_nettype wire

// >>> rtl/tws_pkg.sv
// Package with the shared constants of the two-wire slave port and its master.
// What this block does
// [R1] Device is slave; master clocks every transfer.
// [R2] Bytes travel most significant bit first.
// [R3] Data changes only while clock is low.
// [R4] Device data line undriven after power-up.
// [R5] Device ignores everything until a START.
// [R6] START ignored during power-up sequence.
// [R7] STOP ends operation; device goes standby.
// [R8] Receiver pulls data low on ninth clock.
// [R9] Device acknowledges slave, address, write data.
// [R10] Master acknowledges read bytes to continue.
// [R11] Two slave patterns match; others unacknowledged.
// [R12] Address lowest bit: one read, zero write.
// [R13] Acknowledge only after full matching address byte.
// [R14] Word address byte or internal counter.
// [R15] Address counter cleared to zero at power-up.
// [R16] Random read repeats the same slave address.
// [R17] Write: slave, address, data, STOP, all acknowledged.
// [R18] Read: dummy write, repeated START, read byte.
// [R19] Device sends while master acknowledges.
// [R20] Pointer increments, wraps to zero after last.
// [R21] Backup supply disables the serial interface.
// [R22] Missing master acknowledge releases line, waits.
package tws_pkg;
  localparam logic [6:0] TWS_ID_CSR = 7'h6f;
  localparam logic [6:0] TWS_ID_RAM = 7'h57;
  localparam logic [7:0] TWS_CSR_LAST = 8'h2f;
  localparam logic [7:0] TWS_RAM_LAST = 8'h7f;
  localparam logic [7:0] TWS_PTR_RESET = 8'h00;
  localparam logic [3:0] TWS_BITS = 4'h8;
  localparam int TWS_CLK_HZ = 25000000;
  localparam int TWS_SCL_HALF_NS = 160;
  localparam int TWS_CLK_NS = 40;
  localparam int TWS_HALF_CYC = TWS_SCL_HALF_NS / TWS_CLK_NS;
endpackage : tws_pkg

// >>> rtl/tws_if.sv
// Interface joining the two-wire slave and master ends.
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain wire levels: any enabled driver pulls low.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o,
    output sda_m_oe);
endinterface : tws_if
`default_nettype wire

// >>> rtl/tws_slave.sv
// Device end: two-wire slave giving access to the register and user memory spaces.
`timescale 1ns/1ps
`default_nettype none
module tws_slave import tws_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  tws_if.slave bus,
  input wire logic powerup_busy,
  input wire logic on_backup,
  output logic wr_stb,
  output logic wr_space,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_space,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  typedef enum {TWS_IDLE, TWS_SLV, TWS_WADR, TWS_WDAT, TWS_TX, TWS_WAIT} tws_st_t;
  logic scl_a, scl_s, scl_d, sda_a, sda_s, sda_d;
  tws_st_t st;
  logic [7:0] shreg;
  logic [3:0] bitn;
  logic ack_ph;
  logic space, got_data;
  logic [7:0] ptr;
  logic [7:0] txreg;
  logic drive_low;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s; // [R5]
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  wire en = ~powerup_busy & ~on_backup; // [R6] [R21]
  // The identifier is the upper seven bits; bit 0 is the direction.
  wire [6:0] id = shreg[7:1];
  wire [7:0] last = space ? TWS_RAM_LAST : TWS_CSR_LAST;

  // Two-flop synchronisers on both bus lines.
  always_ff @(posedge core_clk) begin
    scl_a <= bus.scl;
    scl_s <= scl_a;
    scl_d <= scl_s;
    sda_a <= bus.sda;
    sda_s <= sda_a;
    sda_d <= sda_s;
  end

  // Protocol sequencer; bits are sampled on rising clock edges.
  always_ff @(posedge core_clk) begin
    wr_stb <= 1'b0;
    if (!rst_n || !en) begin
      st <= TWS_IDLE; // [R4] [R21]
      bitn <= 4'h0;
      ack_ph <= 1'b0;
      drive_low <= 1'b0;
      shreg <= 8'h00;
      space <= 1'b0;
      got_data <= 1'b0;
      txreg <= 8'h00;
      if (!rst_n) begin
        ptr <= TWS_PTR_RESET; // [R15]
      end
    end else if (start_c) begin
      st <= TWS_SLV; // [R18]
      bitn <= 4'h0;
      ack_ph <= 1'b0;
      drive_low <= 1'b0;
      got_data <= 1'b0; // [R17]
    end else if (stop_c) begin
      st <= TWS_IDLE; // [R7]
      drive_low <= 1'b0;
    end else if (st != TWS_IDLE && st != TWS_WAIT) begin
      if (scl_rise && !ack_ph && st != TWS_TX) begin
        shreg <= {shreg[6:0], sda_s}; // [R2]
        bitn <= bitn + 4'h1;
      end else if (scl_rise && !ack_ph) begin
        bitn <= bitn + 4'h1;
      end else if (scl_rise && ack_ph && st == TWS_TX) begin
        if (sda_s) begin
          st <= TWS_WAIT; // [R22]
        end else begin
          txreg <= rd_data; // [R19]
        end
      end
      if (scl_fall) begin
        if (ack_ph) begin
          // Ack clock finished; release and move on.
          ack_ph <= 1'b0;
          bitn <= 4'h0;
          drive_low <= (st == TWS_TX) ? ~txreg[7] & ~sda_s : 1'b0; // [R3]
          if (st == TWS_TX && !sda_s) begin
            txreg <= {txreg[6:0], 1'b0};
          end
        end else if (bitn == TWS_BITS) begin
          ack_ph <= 1'b1;
          unique case (st)
            TWS_SLV: begin
              if (id == TWS_ID_CSR || id == TWS_ID_RAM) begin // [R11] [R13]
                drive_low <= ~shreg[7] | 1'b1; // [R9]
                space <= (id == TWS_ID_RAM);
                st <= shreg[0] ? TWS_TX : TWS_WADR; // [R12]
                txreg <= rd_data;
              end else begin
                st <= TWS_WAIT;
                drive_low <= 1'b0;
              end
            end
            TWS_WADR: begin
              ptr <= shreg; // [R14]
              drive_low <= 1'b1; // [R9]
              st <= TWS_WDAT;
            end
            TWS_WDAT: begin
              drive_low <= ~got_data; // [R17]
              if (!got_data) begin
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                got_data <= 1'b1;
              end
            end
            TWS_TX: begin
              drive_low <= 1'b0; // [R8]
              ptr <= (ptr >= last) ? TWS_PTR_RESET : ptr + 8'h01; // [R20]
            end
            default: drive_low <= 1'b0;
          endcase
        end else if (st == TWS_TX) begin
          drive_low <= ~txreg[7]; // [R2] [R3]
          txreg <= {txreg[6:0], 1'b0};
        end
      end
    end
  end

  // Registered open-drain enable; the port never pulls while disabled.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus.sda_s_oe <= 1'b0;
    end else begin
      bus.sda_s_oe <= drive_low & en; // [R1] [R4]
    end
  end
  assign bus.sda_s_o = 1'b0;

  // Registered view of the write target and read pointer.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_space <= 1'b0;
      rd_space <= 1'b0;
      rd_addr <= TWS_PTR_RESET;
    end else begin
      wr_space <= space;
      rd_space <= space;
      rd_addr <= ptr;
    end
  end
endmodule : tws_slave
`default_nettype wire

// >>> bench/tws_properties.sv
// Concurrent checks on the two-wire link between the slave and master ends.
`timescale 1ns/1ps
`default_nettype none
module tws_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  logic [7:0] hold;
  // Counts how long the slave keeps pulling the data line without a break.
  always_ff @(posedge core_clk) begin
    if (!rst_n || !sda_s_oe) hold <= 8'h00;
    else if (hold != 8'hff) hold <= hold + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_still_hi; $past(scl) && scl |-> $stable(sda_s_oe); endproperty
  a_still_hi: assert property (p_still_hi) else $error("slave data moved while clock high");
  property p_drive_low; $rose(sda_s_oe) |-> !scl; endproperty
  a_drive_low: assert property (p_drive_low) else $error("slave drive began with clock high");
  property p_hold_bound; hold < 8'h96; endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("slave held data line too long");
  property p_stop_idle; $rose(sda) && scl && $past(scl) |-> !sda_s_oe [*4]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("slave drove after stop");
  property p_start_clk; $fell(sda) && scl && $past(scl) |-> ##[1:40] !scl; endproperty
  a_start_clk: assert property (p_start_clk) else $error("no clock after start");
  property p_no_clash; scl |-> !(sda_s_oe && sda_m_oe); endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drove data line");
  property p_scl_min; $rose(scl) |-> scl [*4]; endproperty
  a_scl_min: assert property (p_scl_min) else $error("clock high phase too short");
  property p_bit_clk; $rose(sda_s_oe) |-> ##[1:40] scl; endproperty
  a_bit_clk: assert property (p_bit_clk) else $error("slave bit not clocked");
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_ack: cover property ($rose(sda_s_oe));
endmodule : tws_properties
`default_nettype wire

// >>> bench/test_i2c_slave_register_port.sv
// Self-checking bench joining the two-wire master and slave ends.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_register_port import tws_pkg::*;;
  logic core_clk, rst_n, powerup_busy, on_backup, cmd_go, cmd_read, cmd_rand, busy;
  logic rd_valid, nack, wr_stb, wr_space, rd_space;
  logic [6:0] cmd_id;
  logic [7:0] cmd_addr, cmd_wdata, cmd_count, rd_byte, wr_addr, wr_data, rd_addr, rd_data;
  logic [7:0] csr [0:255];
  logic [7:0] ram [0:255];
  logic [7:0] got [$];
  int fail_count = 0;
  int samples_checked = 0;
  tws_if bus_if ();
  tws_slave i_tws_slave (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
    .powerup_busy(powerup_busy), .on_backup(on_backup), .wr_stb(wr_stb), .wr_space(wr_space),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_space(rd_space), .rd_addr(rd_addr),
    .rd_data(rd_data));
  tws_master i_tws_master (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if), .cmd_go(cmd_go),
    .cmd_read(cmd_read), .cmd_rand(cmd_rand), .cmd_id(cmd_id), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_count(cmd_count), .busy(busy), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .nack(nack));
  tws_properties i_tws_properties (.core_clk(core_clk), .rst_n(rst_n), .scl(bus_if.scl),
    .sda(bus_if.sda), .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe));
  // Storage behind the slave: register and user spaces, read combinationally.
  assign rd_data = rd_space ? ram[rd_addr] : csr[rd_addr];
  always @(posedge core_clk) begin
    if (wr_stb && wr_space) ram[wr_addr] <= wr_data;
    if (wr_stb && !wr_space) csr[wr_addr] <= wr_data;
    if (rd_valid) got.push_back(rd_byte);
  end
  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check8
  // Issues one master command and waits, bounded, until the bus is idle again.
  task automatic run(input logic rd, input logic rnd, input logic [6:0] id,
    input logic [7:0] a, input logic [7:0] d, input logic [7:0] n);
    int k;
    got.delete();
    cmd_read = rd;
    cmd_rand = rnd;
    cmd_id = id;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_count = n;
    cmd_go = 1'b1;
    @(posedge core_clk);
    #1 cmd_go = 1'b0;
    for (k = 0; busy === 1'b1 && k < 20000; k++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    #1;
    check8("busy after command", 8'h00, {7'h00, busy});
  endtask : run
  task automatic t_current();
    run(1'b1, 1'b0, TWS_ID_CSR, 8'h00, 8'h00, 8'h01);
    check8("current read byte", 8'h5a, got[0]);
    check8("current read count", 8'h01, 8'(got.size()));
    $display("test current read done");
  endtask : t_current
  task automatic t_write();
    run(1'b0, 1'b0, TWS_ID_CSR, 8'h05, 8'ha5, 8'h01);
    check8("csr write nack", 8'h00, {7'h00, nack});
    check8("csr stored", 8'ha5, csr[5]);
    run(1'b0, 1'b0, TWS_ID_RAM, 8'h7f, 8'h3c, 8'h01);
    check8("user write nack", 8'h00, {7'h00, nack});
    check8("user stored", 8'h3c, ram[8'h7f]);
    run(1'b1, 1'b1, TWS_ID_RAM, 8'h7f, 8'h00, 8'h01);
    check8("user read back", 8'h3c, got[0]);
    $display("test write done");
  endtask : t_write
  task automatic t_wrap();
    run(1'b1, 1'b1, TWS_ID_CSR, 8'h2e, 8'h00, 8'h03);
    check8("wrap count", 8'h03, 8'(got.size()));
    check8("wrap byte 0", 8'h2e ^ 8'h5a, got[0]);
    check8("wrap byte 1", 8'h2f ^ 8'h5a, got[1]);
    check8("wrap byte 2", 8'h5a, got[2]);
    $display("test wrap read done");
  endtask : t_wrap
  // Bad identifier, backup supply and power-up each leave the port silent.
  task automatic t_refuse();
    for (int c = 0; c < 3; c++) begin
      on_backup = (c == 1);
      powerup_busy = (c == 2);
      run(1'b0, 1'b0, (c == 0) ? 7'h50 : TWS_ID_CSR, 8'h06, 8'hff, 8'h01);
      check8("refused nack", 8'h01, {7'h00, nack});
      check8("refused store", 8'h06 ^ 8'h5a, csr[6]);
    end
    on_backup = 1'b0;
    powerup_busy = 1'b0;
    $display("test refusal done");
  endtask : t_refuse
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // Main sequence.
  initial begin
    for (int i = 0; i < 256; i++) begin
      csr[i] = 8'(i) ^ 8'h5a;
      ram[i] = ~8'(i);
    end
    rst_n = 1'b0;
    powerup_busy = 1'b0;
    on_backup = 1'b0;
    cmd_go = 1'b0;
    cmd_read = 1'b0;
    cmd_rand = 1'b0;
    cmd_id = 7'h00;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    cmd_count = 8'h01;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    t_current();
    t_write();
    t_wrap();
    t_refuse();
    print_verdict();
  end
  // Watchdog against a hung transfer.
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
endmodule : test_i2c_slave_register_port
`default_nettype wire
